/* design/pcr_pkg.sv */
// Constants for the port 4..8 control write registers.
// Assumes a 250 MHz device clock.
`default_nettype none
package pcr_pkg;
    localparam int unsigned CLK_HZ = 250_000_000;
    // Blink period in ms is 0.00013 x clock in Hz
    localparam longint unsigned BLINK_PERIOD_MS = longint'(CLK_HZ) * 13 / 100_000;
    localparam longint unsigned BLINK_PERIOD_CYC = BLINK_PERIOD_MS * longint'(CLK_HZ) / 1000;
    localparam longint unsigned BLINK_HALF_CYC = BLINK_PERIOD_CYC / 2;
    localparam logic [2:0] REG_PORT_CTRL = 3'h2;
    localparam logic [2:0] PORT_ADDR_FIRST = 3'h3;
    localparam logic [2:0] PORT_ADDR_PORT5 = 3'h4;
    localparam logic [2:0] PORT_ADDR_LAST = 3'h7;
    localparam int NUM_PORTS = 5;
    localparam int BIT_OVERLOAD_DIS = 7;
    localparam int BIT_COMMON_HI = 6;
    localparam int BIT_COMMON_LO = 5;
    localparam int BIT_BLINK = 4;
    localparam int BIT_LED_LOW = 3;
    localparam int BIT_LED_HIGH = 2;
    localparam int MODE_HI = 1;
    localparam int MODE_LO = 0;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_START = 2'h1;
    localparam logic [1:0] MODE_SAMPLE = 2'h2;
    localparam logic [1:0] MODE_POWER_DOWN = 2'h3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
endpackage
`default_nettype wire

/* design/pcr_blink_if.sv */
// Carries the shared blink phase from the timer to the register bank.
// Assumes both ends share one clock.
`default_nettype none
interface pcr_blink_if;
    logic phase;
    modport timer (output phase);
    modport user (input phase);
endinterface
`default_nettype wire

/* design/pcr_blink_timer.sv */
// Free-running fast-blink phase generator.
// Assumes a synchronous active-high reset on the device clock.
`default_nettype none
module pcr_blink_timer
    import pcr_pkg::*;
#(
    parameter int CNT_W = 32,
    parameter longint unsigned HALF_CYC = BLINK_HALF_CYC
)(
    input wire logic clock_in,
    input wire logic rst_in,
    pcr_blink_if.timer blink
);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(HALF_CYC - 1);

    // Refuse a half period the counter cannot reach
    if (CNT_W < 1 || CNT_W > 63 || HALF_CYC < 1 || HALF_CYC > (64'h1 << CNT_W))
    begin : bad_half_cyc
        $error("pcr_blink_timer: HALF_CYC does not fit CNT_W");
    end

    logic [CNT_W-1:0] count;
    logic phase;

    // One phase per half period, so a full on/off cycle is the blink period
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            count <= '0;
            phase <= 1'b1;
        end
        else if (count == LAST)
        begin
            count <= '0;
            phase <= ~phase;
        end
        else
        begin
            count <= count + CNT_W'(1);
        end
    end

    assign blink.phase = phase;
endmodule
`default_nettype wire

/* design/pcr_port_ctrl.sv */
// Port 4..8 control write registers and their decoded outputs.
// Assumes writes come from a same-clock serial front end as one-cycle strobes.
// Operation
// - Mode 00 off, 01 starts power sequence
// - Mode 10 samples current, 11 powers down
// - D7 disables that port's overload timer
// - Port 4 D6 disables all overvoltage timers
// - Port 4 D5 selects converter volts/currents
// - D4 blinks LED at clock-scaled rate
// - D4 clear drives LED continuously
// - D3 enables LED low-side driver
// - D2 enables LED high-side driver
// - Register 010 plus port address 011..111
`default_nettype none
module pcr_port_ctrl
    import pcr_pkg::*;
#(
    parameter int BLINK_CNT_W = 32,
    parameter longint unsigned BLINK_HALF = BLINK_HALF_CYC
)(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic wr_en_in,
    input wire logic [2:0] reg_addr_in,
    input wire logic [2:0] port_addr_in,
    input wire logic [7:0] wr_data_in,
    output logic [NUM_PORTS-1:0] port_off_out,
    output logic [NUM_PORTS-1:0] port_start_out,
    output logic [NUM_PORTS-1:0] sample_current_out,
    output logic [NUM_PORTS-1:0] power_down_out,
    output logic [NUM_PORTS-1:0] overload_timer_dis_out,
    output logic [NUM_PORTS-1:0] led_high_on_out,
    output logic [NUM_PORTS-1:0] led_low_on_out,
    output logic overvoltage_timer_dis_out,
    output logic undervoltage_timer_dis_out,
    output logic adc_select_voltage_out
);
    pcr_blink_if blink_bus();

    pcr_blink_timer #(
        .CNT_W(BLINK_CNT_W),
        .HALF_CYC(BLINK_HALF)
    ) pcr_blink_timer_inst (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .blink(blink_bus.timer)
    );

    // Refuse blink settings the counter cannot serve
    if (BLINK_CNT_W < 1 || BLINK_CNT_W > 63)
    begin : bad_blink_width
        $error("pcr_port_ctrl: BLINK_CNT_W must lie in 1..63");
    end
    if (BLINK_HALF < 1)
    begin : bad_blink_half
        $error("pcr_port_ctrl: BLINK_HALF must be at least 1");
    end

    // Decode of one enable-mode code, shared by the four mode outputs
    function automatic logic mode_is(
        input logic [1:0] field,
        input logic [1:0] code
    );
        return field == code;
    endfunction

    // A driver conducts when enabled, and only in the lit half while blinking
    function automatic logic led_drive(
        input logic enable,
        input logic blink,
        input logic on_phase
    );
        return enable && (!blink || on_phase);
    endfunction

    // Only register 010 with port address 011..111 reaches this bank
    function automatic logic is_port_write(
        input logic wr,
        input logic [2:0] r,
        input logic [2:0] p
    );
        return wr && r == REG_PORT_CTRL && p >= PORT_ADDR_FIRST && p <= PORT_ADDR_LAST;
    endfunction

    // Per-port stored fields
    logic [1:0] mode [NUM_PORTS];
    logic [NUM_PORTS-1:0] blink_en;
    logic [NUM_PORTS-1:0] led_low;
    logic [NUM_PORTS-1:0] led_high;
    // Values the registers take at this edge
    logic [1:0] next_mode [NUM_PORTS];
    logic [NUM_PORTS-1:0] next_overload_dis;
    logic [NUM_PORTS-1:0] next_blink_en;
    logic [NUM_PORTS-1:0] next_led_low;
    logic [NUM_PORTS-1:0] next_led_high;
    logic next_ov_dis;
    logic next_uv_dis;
    logic next_adc_volt;
    logic hit;
    logic [2:0] port_idx;
    logic blink_lit;

    assign hit = is_port_write(wr_en_in, reg_addr_in, port_addr_in);
    assign port_idx = port_addr_in - PORT_ADDR_FIRST;
    assign blink_lit = blink_bus.phase;

    // Per-port next values; a write touches only the addressed port
    always_comb
    begin
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            next_mode[i] = mode[i];
        end
        next_overload_dis = overload_timer_dis_out;
        next_blink_en = blink_en;
        next_led_low = led_low;
        next_led_high = led_high;
        if (hit)
        begin
            next_mode[port_idx] = wr_data_in[MODE_HI:MODE_LO];
            next_overload_dis[port_idx] = wr_data_in[BIT_OVERLOAD_DIS];
            next_blink_en[port_idx] = wr_data_in[BIT_BLINK];
            next_led_low[port_idx] = wr_data_in[BIT_LED_LOW];
            next_led_high[port_idx] = wr_data_in[BIT_LED_HIGH];
        end
    end

    // Common next values: one shared copy; port 5 D6 sets the undervoltage disable, spare bits of ports 6..8 go nowhere
    always_comb
    begin
        next_ov_dis = overvoltage_timer_dis_out;
        next_uv_dis = undervoltage_timer_dis_out;
        next_adc_volt = adc_select_voltage_out;
        if (hit && port_addr_in == PORT_ADDR_FIRST)
        begin
            next_ov_dis = wr_data_in[BIT_COMMON_HI];
            next_adc_volt = wr_data_in[BIT_COMMON_LO];
        end
        else if (hit && port_addr_in == PORT_ADDR_PORT5)
        begin
            next_uv_dis = wr_data_in[BIT_COMMON_HI];
        end
    end

    // Enable modes
    always_ff @(posedge clock_in)
    begin
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            if (rst_in)
            begin
                mode[i] <= CTRL_RESET[MODE_HI:MODE_LO];
            end
            else
            begin
                mode[i] <= next_mode[i];
            end
        end
    end

    // LED controls
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            blink_en <= {NUM_PORTS{CTRL_RESET[BIT_BLINK]}};
            led_low <= {NUM_PORTS{CTRL_RESET[BIT_LED_LOW]}};
            led_high <= {NUM_PORTS{CTRL_RESET[BIT_LED_HIGH]}};
        end
        else
        begin
            blink_en <= next_blink_en;
            led_low <= next_led_low;
            led_high <= next_led_high;
        end
    end

    // Timer disables and converter select; the output flops are the registers
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            overload_timer_dis_out <= {NUM_PORTS{CTRL_RESET[BIT_OVERLOAD_DIS]}};
            overvoltage_timer_dis_out <= CTRL_RESET[BIT_COMMON_HI];
            undervoltage_timer_dis_out <= CTRL_RESET[BIT_COMMON_HI];
            adc_select_voltage_out <= CTRL_RESET[BIT_COMMON_LO];
        end
        else
        begin
            overload_timer_dis_out <= next_overload_dis;
            overvoltage_timer_dis_out <= next_ov_dis;
            undervoltage_timer_dis_out <= next_uv_dis;
            adc_select_voltage_out <= next_adc_volt;
        end
    end

    // Mode outputs load from the next values, so a write shows after one edge
    always_ff @(posedge clock_in)
    begin
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            if (rst_in)
            begin
                port_off_out[i] <= mode_is(CTRL_RESET[MODE_HI:MODE_LO], MODE_OFF);
                port_start_out[i] <= mode_is(CTRL_RESET[MODE_HI:MODE_LO], MODE_START);
                sample_current_out[i] <= mode_is(CTRL_RESET[MODE_HI:MODE_LO], MODE_SAMPLE);
                power_down_out[i] <= mode_is(CTRL_RESET[MODE_HI:MODE_LO], MODE_POWER_DOWN);
            end
            else
            begin
                port_off_out[i] <= mode_is(next_mode[i], MODE_OFF);
                port_start_out[i] <= mode_is(next_mode[i], MODE_START);
                sample_current_out[i] <= mode_is(next_mode[i], MODE_SAMPLE);
                power_down_out[i] <= mode_is(next_mode[i], MODE_POWER_DOWN);
            end
        end
    end

    // LED drive trails the blink phase by one edge, far below what an eye sees
    always_ff @(posedge clock_in)
    begin
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            if (rst_in)
            begin
                led_high_on_out[i] <= 1'b0;
                led_low_on_out[i] <= 1'b0;
            end
            else
            begin
                led_high_on_out[i] <= led_drive(next_led_high[i], next_blink_en[i],
                    blink_lit);
                led_low_on_out[i] <= led_drive(next_led_low[i], next_blink_en[i],
                    blink_lit);
            end
        end
    end
endmodule
`default_nettype wire

/* verif/pcr_port_ctrl_props.sv */
// Checker for the port control write registers.
// Assumes a bind onto pcr_port_ctrl, one clock.
`default_nettype none
module pcr_port_ctrl_props (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic wr_en_in,
    input wire logic [2:0] reg_addr_in,
    input wire logic [2:0] port_addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [4:0] port_off_out,
    input wire logic [4:0] port_start_out,
    input wire logic [4:0] sample_current_out,
    input wire logic [4:0] power_down_out,
    input wire logic [4:0] overload_timer_dis_out,
    input wire logic [4:0] led_high_on_out,
    input wire logic [4:0] led_low_on_out,
    input wire logic overvoltage_timer_dis_out,
    input wire logic adc_select_voltage_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    logic [7:0] pd;
    wire hit = wr_en_in && reg_addr_in == 3'h2 && port_addr_in == 3'h3;
    always_ff @(posedge clock_in) pd <= wr_data_in;
    off_decode_a: assert property (hit |=> port_off_out[0] == (pd[1:0] == 2'h0))
        else $error("off decode wrong");
    start_decode_a: assert property (hit |-> ##1
        port_start_out[0] == (pd[1:0] == 2'h1)) else $error("start decode wrong");
    upper_modes_a: assert property (hit && wr_data_in[1] |=>
        !(port_off_out[0] | port_start_out[0])) else $error("upper mode decode wrong");
    upper_exact_a: assert property (hit |=>
        sample_current_out[0] == (pd[1:0] == 2'h2) && power_down_out[0] == (pd[1:0] == 2'h3))
        else $error("sample or power-down decode wrong");
    overload_dis_a: assert property (hit |=> overload_timer_dis_out[0] == pd[7])
        else $error("overload disable wrong");
    common_ov_a: assert property (hit |=> overvoltage_timer_dis_out == pd[6])
        else $error("overvoltage disable wrong");
    adc_select_a: assert property (hit |=> adc_select_voltage_out == pd[5])
        else $error("converter select wrong");
    steady_led_a: assert property (hit && !wr_data_in[4] |=>
        led_high_on_out[0] == pd[2] && led_low_on_out[0] == pd[3]) else $error("led drive wrong");
    addr_ignore_a: assert property (wr_en_in && reg_addr_in != 3'h2 |=>
        $stable(port_off_out)) else $error("foreign write took effect");
    common_keep_a: assert property (wr_en_in && port_addr_in != 3'h3 |=>
        $stable(adc_select_voltage_out)) else $error("common bit changed");
    cover property (hit && wr_data_in[4]);
    cover property (wr_en_in && port_addr_in == 3'h7);
    cover property (wr_en_in && reg_addr_in != 3'h2);
endmodule
bind pcr_port_ctrl pcr_port_ctrl_props pcr_port_ctrl_props_inst (.*);
`default_nettype wire

/* verif/pcr_host.sv */
// Host model issuing single-byte register writes.
// Assumes the block samples on the rising edge.
`default_nettype none
module pcr_host (
    input wire logic clock_in,
    output logic wr_en_out,
    output logic [2:0] reg_out,
    output logic [2:0] port_out,
    output logic [7:0] data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {wr_en_out, reg_out, port_out, data_out} = 15'h0;
    task automatic write(input logic [2:0] r, input logic [2:0] p, input logic [7:0] d);
        @(negedge clock_in);
        {wr_en_out, reg_out, port_out, data_out} = {1'b1, r, p, d};
        @(negedge clock_in);
        // Released lines show junk, not the old value
        {wr_en_out, reg_out, port_out, data_out} = {1'b0, ~r, ~p, ~d};
    endtask
endmodule
`default_nettype wire

/* verif/pcr_port_ctrl_test.sv */
// Self-checking bench for the port control write registers.
// Short blink half period keeps the run brief.
`default_nettype none
module pcr_port_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 0;
    logic rst_in = 1;
    logic wr_en_in;
    logic [2:0] reg_addr_in, port_addr_in;
    logic [7:0] wr_data_in;
    logic [4:0] port_off_out, port_start_out, sample_current_out, power_down_out;
    logic [4:0] overload_timer_dis_out, led_high_on_out, led_low_on_out;
    logic overvoltage_timer_dis_out, undervoltage_timer_dis_out, adc_select_voltage_out;
    logic [7:0] m [5];
    logic ov, uv, adc;
    int n_errors = 0;
    int checks_done = 0;
    int seed = 32'h765f;
    initial forever #2 clock_in = ~clock_in;
    pcr_host pcr_host_inst (.clock_in(clock_in), .wr_en_out(wr_en_in), .reg_out(reg_addr_in),
        .port_out(port_addr_in), .data_out(wr_data_in));
    pcr_port_ctrl #(.BLINK_CNT_W(4), .BLINK_HALF(4)) pcr_port_ctrl_inst (.*);
    task automatic chk(input logic [4:0] got, input logic [4:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [2:0] r, input logic [2:0] p, input logic [7:0] d);
        logic [4:0] e [4];
        logic [4:0] b, h, l, v;
        pcr_host_inst.write(r, p, d);
        if (r == 3'h2 && p > 3'h2) m[p - 3'h3] = d;
        if (r == 3'h2 && p == 3'h3) {ov, adc} = d[6:5];
        if (r == 3'h2 && p == 3'h4) uv = d[6];
        for (int i = 0; i < 5; i++)
        begin
            for (int k = 0; k < 4; k++) e[k][i] = m[i][1:0] == 2'(k);
            {v[i], b[i], l[i], h[i]} = {m[i][7], m[i][4:2]};
        end
        chk(port_off_out, e[0]);
        chk(port_start_out, e[1]);
        chk(sample_current_out, e[2]);
        chk(power_down_out, e[3]);
        chk(overload_timer_dis_out, v);
        chk(5'(overvoltage_timer_dis_out), 5'(ov));
        chk(5'(adc_select_voltage_out), 5'(adc));
        chk(5'(undervoltage_timer_dis_out), 5'(uv));
        chk(led_high_on_out & ~b, h & ~b);
        chk(led_low_on_out & ~b, l & ~b);
    endtask
    // Edges spent at one LED level, bounded so a stuck LED cannot hang the run
    task automatic run_len(input logic lvl, output int len);
        len = 0;
        while (led_high_on_out[0] === lvl && len < 40)
        begin
            @(negedge clock_in);
            len++;
        end
    endtask
    task automatic do_reset;
        rst_in = 1;
        repeat (20) @(negedge clock_in);
        rst_in = 0;
        foreach (m[i]) m[i] = 8'h00;
        {ov, uv, adc} = 3'h0;
        put(3'h0, 3'h3, 8'hff);
    endtask
    task automatic end_of_test;
        $display("errors=%0d checks=%0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        int n;
        logic lvl;
        do_reset;
        put(3'h2, 3'h3, 8'h9d);
        put(3'h2, 3'h4, 8'h66);
        for (int k = 0; k < 4; k++) put(3'h2, 3'h7, 8'(k));
        put(3'h2, 3'h3, 8'h14);
        n = 0;
        repeat (8)
        begin
            @(negedge clock_in);
            n += led_high_on_out[0];
        end
        chk(5'(n), 5'h4);
        lvl = led_high_on_out[0];
        run_len(lvl, n);
        run_len(!lvl, n);
        chk(5'(n), 5'h4);
        run_len(lvl, n);
        chk(5'(n), 5'h4);
        repeat (200) put({1'b0, 1'($random(seed)), 1'b0}, 3'($random(seed)),
            8'($random(seed)));
        do_reset;
        end_of_test;
    end
endmodule
`default_nettype wire
